//--- testbench/ndc_counter_display_bench.sv
module ndc_counter_display_bench;
   import ndc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic count_clock = 1'b0;
   logic clear = 1'b0;
   logic recall = 1'b0;
   logic save_n = 1'b1;
   logic output_enable = 1'b0;
   logic leading_zero_blank = 1'b0;
   logic scan_osc;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [3:0] wb_adr = 4'h0;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0;
   logic [31:0] wb_rdat;
   logic wb_ack;
   logic [6:0] seg;
   logic [5:0] strb;
   logic ovf;
   logic [31:0] rd;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [6:0] seg_tbl [10] = '{NDC_SEG_0, NDC_SEG_1, NDC_SEG_2, NDC_SEG_3, NDC_SEG_4,
                                NDC_SEG_5, NDC_SEG_6, NDC_SEG_7, NDC_SEG_8, NDC_SEG_9};

   always #5 mclk = ~mclk;

   ndc_counter_display dut_u (
      .mclk(mclk), .reset_n(reset_n), .count_clock(count_clock), .clear(clear),
      .recall(recall), .save_n(save_n), .output_enable(output_enable),
      .leading_zero_blank(leading_zero_blank), .scan_osc(scan_osc),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .segment_a_output(seg[6]), .segment_b_output(seg[5]), .segment_c_output(seg[4]),
      .segment_d_output(seg[3]), .segment_e_output(seg[2]), .segment_f_output(seg[1]),
      .segment_g_output(seg[0]), .digit_strobe_msd(strb[5]), .digit_strobe_5(strb[4]),
      .digit_strobe_4(strb[3]), .digit_strobe_3(strb[2]), .digit_strobe_2(strb[1]),
      .digit_strobe_lsd(strb[0]), .overflow_output(ovf)
   );

   ndc_display_model disp_u (
      .mclk(mclk), .reset_n(reset_n), .seg(seg), .strobe(strb), .scan_osc(scan_osc)
   );

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // classic single cycle; ack sampled at the edge, before its own update lands
   task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd);
      @(posedge mclk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= 4'hF;
      wb_wdat <= wd;
      // only the bench cycle ceiling ends a wait for ack
      do begin
         @(posedge mclk);
      end while (wb_ack !== 1'b1);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic wb_check(input string what, input logic [3:0] adr, input logic [31:0] exp);
      wb_xfer(1'b0, adr, 32'h0);
      check(what, rd, exp);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // high held two mclk and low three between pulses, the shortest the pins allow
   task automatic count_pulses(input int n);
      repeat (n) begin
         @(posedge mclk) count_clock <= 1'b1;
         wait_cyc(2);
         count_clock <= 1'b0;
         wait_cyc(2);
      end
   endtask

   // stale captures are cleared so a missing refresh shows up
   task automatic refresh_view();
      for (int i = 0; i < 6; i++) disp_u.seen[i] = NDC_SEG_OFF;
      wait_cyc(110);
   endtask

   task automatic check_blank();
      wait_cyc(2);
      check("display off", {18'h0, seg, strb, ovf}, 32'h0);
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         print_verdict();
      end
   end

   initial begin
      wait_cyc(3);
      reset_n <= 1'b1;
      wb_check("ctrl reset", NDC_ADR_CTRL, 32'h1);
      wb_xfer(1'b1, NDC_ADR_STATUS, 32'hFF);
      wb_check("status", NDC_ADR_STATUS, 32'h10);
      wb_check("unmapped", 4'h2, 32'h0);
      wb_check("count reset", NDC_ADR_COUNT, 32'h0);
      wait_cyc(60);
      check_blank();
      output_enable <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         refresh_view();
         check("lsd", {25'h0, disp_u.seen[0]}, {25'h0, seg_tbl[i % 10]});
         check("tens", {25'h0, disp_u.seen[1]}, {25'h0, seg_tbl[i / 10]});
         count_pulses(1);
      end
      leading_zero_blank <= 1'b1;
      refresh_view();
      check("msd", {25'h0, disp_u.seen[5]}, {25'h0, NDC_SEG_OFF});
      check("digit 2", {25'h0, disp_u.seen[2]}, {25'h0, NDC_SEG_OFF});
      check("tens", {25'h0, disp_u.seen[1]}, {25'h0, NDC_SEG_1});
      leading_zero_blank <= 1'b0;
      save_n <= 1'b0;
      wait_cyc(4);
      wb_check("status", NDC_ADR_STATUS, 32'h8);
      count_pulses(2);
      clear <= 1'b1;
      wait_cyc(4);
      clear <= 1'b0;
      wait_cyc(2);
      save_n <= 1'b1;
      wait_cyc(3);
      wb_check("stored", NDC_ADR_STORED, 32'h12);
      wb_check("count", NDC_ADR_COUNT, 32'h12);
      count_pulses(3);
      wb_check("count", NDC_ADR_COUNT, 32'h15);
      clear <= 1'b1;
      wait_cyc(3);
      wb_check("status", NDC_ADR_STATUS, 32'h2);
      recall <= 1'b1;
      count_pulses(2);
      save_n <= 1'b0;
      check_blank();
      wb_check("count", NDC_ADR_COUNT, 32'h0);
      save_n <= 1'b1;
      recall <= 1'b0;
      wait_cyc(2);
      clear <= 1'b0;
      wait_cyc(2);
      recall <= 1'b1;
      wait_cyc(3);
      wb_check("status", NDC_ADR_STATUS, 32'h4);
      count_pulses(2);
      check_blank();
      wb_check("count", NDC_ADR_COUNT, 32'h12);
      clear <= 1'b1;
      wait_cyc(3);
      wb_check("status", NDC_ADR_STATUS, 32'h2);
      clear <= 1'b0;
      recall <= 1'b0;
      refresh_view();
      check("lsd", {25'h0, disp_u.seen[0]}, {25'h0, NDC_SEG_0});
      check("msd", {25'h0, disp_u.seen[5]}, {25'h0, NDC_SEG_0});
      wb_xfer(1'b1, NDC_ADR_CTRL, 32'h0);
      check_blank();
      wb_xfer(1'b1, NDC_ADR_CTRL, 32'h1);
      @(posedge mclk) count_clock <= 1'b1;
      wait_cyc(2);
      save_n <= 1'b0;
      wait_cyc(3);
      wb_check("status", NDC_ADR_STATUS, 32'h10);
      save_n <= 1'b1;
      count_clock <= 1'b0;
      wait_cyc(3);
      wb_check("count", NDC_ADR_COUNT, 32'h1);
      check("scan order", disp_u.order_errors, 32'h0);
      print_verdict();
   end
endmodule

//--- testbench/ndc_display_model.sv
module ndc_display_model
   import ndc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [6:0] seg,
   input wire logic [5:0] strobe,
   output logic scan_osc
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [6:0] seen [6];
   int order_errors = 0;
   int div = 0;
   int last_pos = 5;

   // free-running external scan clock, 8 mclk per period; one process drives it
   always @(posedge mclk) begin
      if (!reset_n) begin
         div = 0;
         scan_osc <= 1'b0;
      end else begin
         div = div + 1;
         if (div == 4) begin
            div = 0;
            scan_osc <= ~scan_osc;
         end
      end
   end

   // a restart at msd is legal at any time, otherwise the same digit or one step down
   always @(posedge mclk) begin
      int pos;
      pos = -1;
      if (reset_n && strobe != 6'h00) begin
         for (int i = 0; i < 6; i++) begin
            if (strobe[i]) pos = i;
         end
         if (!$onehot(strobe)) order_errors++;
         else if (pos != last_pos && pos != 5 && pos != last_pos - 1) order_errors++;
         if (pos >= 0) begin
            seen[pos] = seg;
            last_pos = pos;
         end
      end
   end
endmodule

//--- verilog/ndc_counter_display.sv
// Functional notes
// RQ1 - six synchronous bcd decades count up on each falling count clock edge
// RQ2 - a count edge at 999999 sets overflow latch and wraps to 000000
// RQ3 - enabled segments a..g follow the fixed digit pattern table
// RQ4 - output enable low blanks segments, strobes, overflow; scan held at msd
// RQ5 - scan steps msd to lsd on each falling scan edge, one period per digit
// RQ6 - overflow output follows overflow latch directly, not multiplexed
// RQ7 - leading zero blank high and no overflow blanks leading zero digits
// RQ8 - clear high with save high: reset counter and latch, blank, reset scan
// RQ9 - in clear save is ignored; clear high always ignores recall and clock
// RQ10 - recall high, clear low, save high: load from store, blank, reset scan
// RQ11 - in recall save is ignored; recall high ignores the count clock
// RQ12 - count mode when recall, clear low and save high; clock high locks save
// RQ13 - save low with others low stores counter and latch; locked till save high
// RQ14 - a save fall racing another rise enters exactly one mode safely
// RQ15 - controller may switch modes directly after each minimum mode time
// RQ16 - controller holds save about ten milliseconds for full retention
// RQ17 - controller keeps save high outside intended saves, power edges included
// RQ18 - controller may drive the scan input from an external clock
// RQ19 - blanking and scan reset last through clear or recall, then resume at msd
// RQ20 - an invalid bcd digit decodes to a fixed defined pattern
//
// Chosen here: register access over Wishbone and the register addresses.
module ndc_counter_display
   import ndc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic count_clock,
   input wire logic clear,
   input wire logic recall,
   input wire logic save_n,
   input wire logic output_enable,
   input wire logic leading_zero_blank,
   input wire logic scan_osc,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic segment_a_output,
   output logic segment_b_output,
   output logic segment_c_output,
   output logic segment_d_output,
   output logic segment_e_output,
   output logic segment_f_output,
   output logic segment_g_output,
   output logic digit_strobe_msd,
   output logic digit_strobe_5,
   output logic digit_strobe_4,
   output logic digit_strobe_3,
   output logic digit_strobe_2,
   output logic digit_strobe_lsd,
   output logic overflow_output
);

   ndc_mode_t mode_q, mode_d;
   logic count_clock_q;
   logic scan_osc_q;
   logic [NDC_COUNT_W-1:0] count_q, count_d;
   logic ovf_q, ovf_d;
   logic [NDC_COUNT_W-1:0] nv_count_q;
   logic nv_ovf_q;
   logic [1:0] ctrl_q;
   logic [2:0] scan_q, scan_d;
   logic [6:0] seg_q, seg_d;
   logic [5:0] strobe_q, strobe_d;
   logic ovf_out_q;
   logic ack_q;
   logic [31:0] dat_q;

   // a mode is only chosen from a full set of sampled levels, so a racing
   // save fall and other rise resolve to exactly one mode per edge
   function automatic ndc_mode_t pick_mode(input logic clr, input logic rcl,
                                           input logic sv_n, input logic clk,
                                           input ndc_mode_t hold);
      if (clr && sv_n)
         pick_mode = NDC_CLEAR;
      else if (rcl && !clr && sv_n)
         pick_mode = NDC_RECALL;
      else if (!sv_n && !clr && !rcl && !clk)
         pick_mode = NDC_SAVE;
      else if (sv_n && !clr && !rcl)
         pick_mode = NDC_COUNT;
      else
         pick_mode = hold;
   endfunction

   // clock high masks save while counting
   wire save_eff_n = save_n | count_clock; // see RQ12

   always_comb begin
      case (mode_q)
         NDC_CLEAR: begin
            if (clear)
               mode_d = NDC_CLEAR; // see RQ9
            else
               mode_d = pick_mode(1'b0, recall, save_n, count_clock, NDC_COUNT);
         end
         NDC_RECALL: begin
            if (clear)
               mode_d = NDC_CLEAR;
            else if (recall)
               mode_d = NDC_RECALL; // see RQ11
            else
               mode_d = pick_mode(1'b0, 1'b0, save_n, count_clock, NDC_COUNT);
         end
         NDC_SAVE: begin
            if (!save_n)
               mode_d = NDC_SAVE; // see RQ13
            else
               mode_d = pick_mode(clear, recall, 1'b1, count_clock, NDC_COUNT);
         end
         NDC_COUNT: begin
            mode_d = pick_mode(clear, recall, save_eff_n, count_clock, NDC_COUNT); // see RQ14
         end
         default: mode_d = NDC_COUNT;
      endcase
   end

   wire in_clear = (mode_q == NDC_CLEAR);
   wire in_recall = (mode_q == NDC_RECALL);
   wire in_save = (mode_q == NDC_SAVE);
   wire in_count = (mode_q == NDC_COUNT);
   wire count_fall = count_clock_q & ~count_clock;
   // clear or recall rising inhibits the edge through mode_d
   wire count_en = in_count & (mode_d == NDC_COUNT) & count_fall; // see RQ1 RQ9 RQ11
   wire save_start = (mode_d == NDC_SAVE) & ~in_save;

   logic [NDC_DECADES:0] carry;
   logic [NDC_COUNT_W-1:0] count_inc;
   assign carry[0] = count_en;

   genvar gi;
   generate
      for (gi = 0; gi < NDC_DECADES; gi = gi + 1) begin : g_dec
         wire [3:0] cur = count_q[gi*NDC_BCD_W +: NDC_BCD_W];
         wire is_nine = (cur == 4'h9);
         assign count_inc[gi*NDC_BCD_W +: NDC_BCD_W] =
            carry[gi] ? (is_nine ? 4'h0 : cur + 4'h1) : cur; // see RQ1
         assign carry[gi+1] = carry[gi] & is_nine;
      end
   endgenerate

   always_comb begin
      if (in_clear) begin
         count_d = '0; // see RQ8
         ovf_d = 1'b0;
      end else if (in_recall) begin
         count_d = nv_count_q; // see RQ10
         ovf_d = nv_ovf_q;
      end else begin
         count_d = count_inc;
         ovf_d = ovf_q | carry[NDC_DECADES]; // see RQ2
      end
   end

   // display path
   wire disp_allow = output_enable & ctrl_q[NDC_CTRL_DISP_BIT];
   wire blank = ~disp_allow | in_clear | in_recall; // see RQ4 RQ8 RQ10 RQ19
   wire lzb_on = leading_zero_blank | ctrl_q[NDC_CTRL_LZB_BIT];
   // scan input may be an external clock; it is sampled like any level
   wire scan_fall = scan_osc_q & ~scan_osc; // see RQ18

   always_comb begin
      if (blank)
         scan_d = NDC_SCAN_MSD; // see RQ4 RQ19
      else if (scan_fall && scan_q == NDC_SCAN_LSD)
         scan_d = NDC_SCAN_MSD;
      else if (scan_fall)
         scan_d = scan_q - 3'h1; // see RQ5
      else
         scan_d = scan_q;
   end

   logic [NDC_DECADES-1:0] lead_zero;
   generate
      for (gi = 0; gi < NDC_DECADES; gi = gi + 1) begin : g_lz
         wire dz = (count_q[gi*NDC_BCD_W +: NDC_BCD_W] == 4'h0);
         if (gi == NDC_DECADES - 1) begin : g_top
            assign lead_zero[gi] = dz;
         end else begin : g_rest
            assign lead_zero[gi] = dz & lead_zero[gi+1];
         end
      end
   endgenerate

   wire [3:0] cur_digit = count_q[{scan_q, 2'b00} +: NDC_BCD_W];
   // the lsd stays visible so an all-zero count still shows a digit
   wire lz_hide = lzb_on & ~ovf_q & lead_zero[scan_q] & (scan_q != NDC_SCAN_LSD); // see RQ7
   wire [6:0] seg_dec;

   ndc_seg_decode u_dec (
      .bcd(cur_digit),
      .seg(seg_dec)
   );

   assign seg_d = (blank | lz_hide) ? NDC_SEG_OFF : seg_dec; // see RQ3
   assign strobe_d = blank ? 6'h00 : (6'h01 << scan_q); // see RQ5

   // wishbone slave, one wait state per access
   wire wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire ctrl_wr = wb_req & wb_we_i & (wb_adr_i == NDC_ADR_CTRL) & wb_sel_i[0];
   wire [31:0] stat_word = {27'h0, in_count, in_save, in_recall, in_clear, ovf_q};
   wire [31:0] count_word = {7'h0, ovf_q, count_q};
   wire [31:0] stored_word = {7'h0, nv_ovf_q, nv_count_q};
   wire [31:0] rd_word =
      (wb_adr_i == NDC_ADR_CTRL) ? {30'h0, ctrl_q} :
      (wb_adr_i == NDC_ADR_STATUS) ? stat_word :
      (wb_adr_i == NDC_ADR_COUNT) ? count_word :
      (wb_adr_i == NDC_ADR_STORED) ? stored_word : 32'h0;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= NDC_CLEAR;
         count_clock_q <= 1'b0;
         scan_osc_q <= 1'b0;
         count_q <= '0;
         ovf_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         count_clock_q <= count_clock;
         scan_osc_q <= scan_osc;
         count_q <= count_d;
         ovf_q <= ovf_d;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         nv_count_q <= '0;
         nv_ovf_q <= 1'b0;
      end else if (save_start) begin
         nv_count_q <= count_q; // see RQ13
         nv_ovf_q <= ovf_q;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         scan_q <= NDC_SCAN_MSD;
         seg_q <= NDC_SEG_OFF;
         strobe_q <= 6'h00;
         ovf_out_q <= 1'b0;
      end else begin
         scan_q <= scan_d;
         seg_q <= seg_d;
         strobe_q <= strobe_d;
         ovf_out_q <= ~blank & ovf_q; // see RQ6
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= NDC_CTRL_RESET;
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         ack_q <= wb_req;
         if (ctrl_wr)
            ctrl_q <= wb_dat_i[1:0];
         if (wb_req)
            dat_q <= rd_word;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign segment_a_output = seg_q[6];
   assign segment_b_output = seg_q[5];
   assign segment_c_output = seg_q[4];
   assign segment_d_output = seg_q[3];
   assign segment_e_output = seg_q[2];
   assign segment_f_output = seg_q[1];
   assign segment_g_output = seg_q[0];
   assign digit_strobe_msd = strobe_q[5];
   assign digit_strobe_5 = strobe_q[4];
   assign digit_strobe_4 = strobe_q[3];
   assign digit_strobe_3 = strobe_q[2];
   assign digit_strobe_2 = strobe_q[1];
   assign digit_strobe_lsd = strobe_q[0];
   assign overflow_output = ovf_out_q;

   AST_INC_UNIT: assert property (@(posedge mclk) disable iff (!reset_n) // see RQ1
      count_en && count_q[3:0] != 4'h9 |=> count_q[3:0] == $past(count_q[3:0]) + 4'h1)
      else $error("units decade did not advance");

   AST_WRAP: assert property (@(posedge mclk) disable iff (!reset_n) // see RQ2
      count_en && count_q == 24'h999999 |=> count_q == 24'h000000 && ovf_q)
      else $error("wrap at maximum failed");

   AST_OE_BLANK: assert property (@(posedge mclk) disable iff (!reset_n) // see RQ4
      !output_enable |=> seg_q == NDC_SEG_OFF && strobe_q == 6'h00 && !overflow_output
                         && scan_q == NDC_SCAN_MSD)
      else $error("outputs not blanked with enable low");

   AST_SCAN_STEP: assert property (@(posedge mclk) disable iff (!reset_n) // see RQ5
      !blank && scan_fall && scan_q != NDC_SCAN_LSD |=> scan_q == $past(scan_q) - 3'h1)
      else $error("scan did not step down");

   AST_OVF_OUT: assert property (@(posedge mclk) disable iff (!reset_n) // see RQ6
      !blank && ovf_q |=> overflow_output)
      else $error("overflow output not following latch");

   AST_LZB_MSD: assert property (@(posedge mclk) disable iff (!reset_n) // see RQ7
      leading_zero_blank && !ovf_q && !blank && scan_q == NDC_SCAN_MSD
      && count_q[23:20] == 4'h0 |=> seg_q == NDC_SEG_OFF && strobe_q[5])
      else $error("leading zero not blanked");

   AST_CLEAR_RESET: assert property (@(posedge mclk) disable iff (!reset_n) // see RQ8
      in_clear |=> count_q == 24'h000000 && !ovf_q)
      else $error("clear did not reset counter");

   AST_CLEAR_HOLD: assert property (@(posedge mclk) disable iff (!reset_n) // see RQ9
      in_clear && clear |=> in_clear && count_q == 24'h000000 && !ovf_q)
      else $error("clear mode left while clear high");

   AST_RECALL_LOAD: assert property (@(posedge mclk) disable iff (!reset_n) // see RQ10
      in_recall && !clear |=> count_q == $past(nv_count_q) && ovf_q == $past(nv_ovf_q))
      else $error("recall did not load stored value");

   AST_COUNT_LOCK: assert property (@(posedge mclk) disable iff (!reset_n) // see RQ12
      in_count && count_clock && !clear && !recall |=> in_count)
      else $error("save not masked while clock high");

   AST_SAVE_STORE: assert property (@(posedge mclk) disable iff (!reset_n) // see RQ13
      $rose(in_save) |-> nv_count_q == $past(count_q) && nv_ovf_q == $past(ovf_q))
      else $error("save did not store counter");

   AST_SAVE_LOCK: assert property (@(posedge mclk) disable iff (!reset_n) // see RQ13
      in_save && !save_n |=> in_save && $stable(count_q))
      else $error("save mode not locked");

   COV_WRAP: cover property (@(posedge mclk) disable iff (!reset_n)
      count_en && count_q == 24'h999999);
   COV_SAVE: cover property (@(posedge mclk) disable iff (!reset_n) $rose(in_save));
   COV_RECALL: cover property (@(posedge mclk) disable iff (!reset_n)
      in_recall ##1 in_count);
   COV_LZB: cover property (@(posedge mclk) disable iff (!reset_n) !blank && lz_hide);

endmodule

//--- verilog/ndc_pkg.sv
package ndc_pkg;

   localparam int NDC_DECADES = 6;
   localparam int NDC_BCD_W = 4;
   localparam int NDC_COUNT_W = NDC_DECADES * NDC_BCD_W;

   // wishbone byte offsets
   localparam logic [3:0] NDC_ADR_CTRL = 4'h0;
   localparam logic [3:0] NDC_ADR_STATUS = 4'h4;
   localparam logic [3:0] NDC_ADR_COUNT = 4'h8;
   localparam logic [3:0] NDC_ADR_STORED = 4'hC;

   // control register fields
   localparam int NDC_CTRL_DISP_BIT = 0;
   localparam int NDC_CTRL_LZB_BIT = 1;
   localparam logic [1:0] NDC_CTRL_RESET = 2'h1;

   // status register fields
   localparam int NDC_STAT_OVF_BIT = 0;
   localparam int NDC_STAT_CLEAR_BIT = 1;
   localparam int NDC_STAT_RECALL_BIT = 2;
   localparam int NDC_STAT_SAVE_BIT = 3;
   localparam int NDC_STAT_COUNT_BIT = 4;

   // overflow flag position in the count and stored registers
   localparam int NDC_VAL_OVF_BIT = 24;

   // scan positions, msd first
   localparam logic [2:0] NDC_SCAN_MSD = 3'h5;
   localparam logic [2:0] NDC_SCAN_LSD = 3'h0;

   // segment patterns, bit 6 = a ... bit 0 = g
   localparam logic [6:0] NDC_SEG_0 = 7'h7E;
   localparam logic [6:0] NDC_SEG_1 = 7'h30;
   localparam logic [6:0] NDC_SEG_2 = 7'h6D;
   localparam logic [6:0] NDC_SEG_3 = 7'h79;
   localparam logic [6:0] NDC_SEG_4 = 7'h33;
   localparam logic [6:0] NDC_SEG_5 = 7'h5B;
   localparam logic [6:0] NDC_SEG_6 = 7'h5F;
   localparam logic [6:0] NDC_SEG_7 = 7'h70;
   localparam logic [6:0] NDC_SEG_8 = 7'h7F;
   localparam logic [6:0] NDC_SEG_9 = 7'h7B;
   localparam logic [6:0] NDC_SEG_BAD = 7'h3E;
   localparam logic [6:0] NDC_SEG_OFF = 7'h00;

   typedef enum logic [1:0] {
      NDC_COUNT,
      NDC_CLEAR,
      NDC_RECALL,
      NDC_SAVE
   } ndc_mode_t;

endpackage

//--- verilog/ndc_seg_decode.sv
module ndc_seg_decode
   import ndc_pkg::*;
(
   input wire logic [3:0] bcd,
   output logic [6:0] seg
);

   always_comb begin
      case (bcd)
         4'h0: seg = NDC_SEG_0; // see RQ3
         4'h1: seg = NDC_SEG_1;
         4'h2: seg = NDC_SEG_2;
         4'h3: seg = NDC_SEG_3;
         4'h4: seg = NDC_SEG_4;
         4'h5: seg = NDC_SEG_5;
         4'h6: seg = NDC_SEG_6;
         4'h7: seg = NDC_SEG_7;
         4'h8: seg = NDC_SEG_8;
         4'h9: seg = NDC_SEG_9;
         default: seg = NDC_SEG_BAD; // see RQ20
      endcase
   end

endmodule
